//--- design/wdog_dev_end.sv
// watchdog control register, timed unlock and timeout counter
// Summary of operation
// - select codes 0..9 give 2048 doubling cycles
// - level 1 starts disabled, plain enable
// - level 1 unlock only needed to disable
// - unlock write sets unlock and enable
// - level 1 final write within four cycles
// - level 2 always enabled, reads one
// - level 2 unlock writes unlock and enable
// - level 2 final write sets timeout only
// - watchdog reset restarts at vector zero
// - software masks interrupts during sequence
// - unlock write keeps current timeout
// - unlock bit self-clears after four cycles
// - reset flag forces enable in level 1
// - software clears flag before disabling
`default_nettype none
module wdog_dev_end
  import wdog_pkg::*;
(
  // clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         rst_in,
  // straps and status
  input  wire logic         safety_level2_in,
  input  wire logic         ext_reset_flag_in,
  output logic              wdog_reset_out,
  output logic [15:0]       restart_addr_out,
  output logic              running_out,
  // core side
  wdog_if.device            bus
);
  // strap pins
  logic [1:0]       pin_raw;
  logic [1:0]       pin_s1_q;
  logic [1:0]       pin_s2_q;
  logic [1:0]       pin_s3_q;
  logic [1:0]       pin_q;
  logic [1:0]       pin_d;
  logic [1:0]       pin_agree;
  logic             started_q;
  logic             started_d;
  logic             lvl2_q;
  logic             lvl2_d;
  // write decode
  logic             w_unl;
  logic             w_en;
  logic [SEL_W-1:0] w_sel;
  logic             w_arm;
  logic             w_final;
  logic             w_plain;
  // unlock window
  logic             unl_q;
  logic             unl_d;
  logic [2:0]       ucnt_q;
  logic [2:0]       ucnt_d;
  // configuration
  logic             en_q;
  logic             en_d;
  logic [SEL_W-1:0] sel_q;
  logic [SEL_W-1:0] sel_d;
  logic             en_eff;
  // timeout counter
  logic [7:0]       div_q;
  logic [7:0]       div_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] limit;
  logic             tick;
  logic             fire_q;
  logic             fire_d;
  // reset cause flag and outputs
  logic             flag_q;
  logic             flag_d;
  logic             running_q;
  logic             running_d;
  logic [15:0]      addr_q;
  logic [15:0]      addr_d;

  assign pin_raw   = {ext_reset_flag_in, safety_level2_in};
  assign pin_agree = ~(pin_s2_q ^ pin_s3_q);

  // a level counts only once two stages agree, so a glitch is ignored
  always_comb begin
    pin_d     = (pin_agree & pin_s3_q) | (~pin_agree & pin_q);
    started_d = 1'b1;
    lvl2_d    = started_q ? lvl2_q : pin_q[0];
  end

  // no reset: the straps must be settled when reset lifts
  always_ff @(posedge clk_sys_in) begin
    pin_s1_q <= pin_raw;
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
    pin_q    <= pin_d;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      started_q <= 1'b0;
      lvl2_q    <= 1'b0;
    end else begin
      started_q <= started_d;
      lvl2_q    <= lvl2_d;
    end
  end

  assign w_unl   = bus.wr_data[BIT_UNLOCK];
  assign w_en    = bus.wr_data[BIT_ENABLE];
  assign w_sel   = {bus.wr_data[BIT_SEL3], bus.wr_data[2:0]};
  assign w_arm   = bus.wr_en & w_unl & w_en;
  assign w_final = bus.wr_en & ~w_arm & unl_q;
  assign w_plain = bus.wr_en & ~w_arm & ~unl_q;

  always_comb begin
    unl_d  = unl_q;
    ucnt_d = ucnt_q;
    // window closes by itself four cycles after opening
    if (unl_q) begin
      if (ucnt_q == UNLOCK_CNT_MAX - 3'h1) begin
        unl_d  = 1'b0;
        ucnt_d = 3'h0;
      end else begin
        ucnt_d = ucnt_q + 3'h1;
      end
    end
    if (w_arm) begin
      unl_d  = 1'b1;
      ucnt_d = 3'h0;
    end else if (w_final) begin
      // one protected write per window
      unl_d  = 1'b0;
      ucnt_d = 3'h0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      unl_q  <= 1'b0;
      ucnt_q <= 3'h0;
    end else begin
      unl_q  <= unl_d;
      ucnt_q <= ucnt_d;
    end
  end

  always_comb begin
    en_d  = en_q;
    sel_d = sel_q;
    if (w_arm) begin
      if (!lvl2_q) begin
        sel_d = w_sel;
      end
    end else if (w_final) begin
      sel_d = w_sel;
      if (!lvl2_q) begin
        en_d = w_en;
      end
    end else if (w_plain && !lvl2_q) begin
      // outside window: enable may rise, never fall
      if (w_en) begin
        en_d = 1'b1;
      end
      sel_d = w_sel;
    end
    // flag holds the enable bit itself set, not only its read value
    if (flag_q && !lvl2_q) begin
      en_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      en_q  <= 1'b0;
      sel_q <= SEL_RST;
    end else begin
      en_q  <= en_d;
      sel_q <= sel_d;
    end
  end

  assign en_eff = lvl2_q | en_q | (flag_q & ~lvl2_q);
  // reserved codes saturate to the longest timeout
  assign limit = (sel_q > SEL_MAX) ? CNT_W'(BASE_CYCLES << SEL_MAX)
               : CNT_W'(BASE_CYCLES << sel_q);
  assign tick  = (div_q == 8'(OSC_DIV - 1));

  always_comb begin
    div_d  = tick ? 8'h00 : div_q + 8'h01;
    cnt_d  = cnt_q;
    fire_d = 1'b0;
    if (bus.kick || !en_eff) begin
      cnt_d = '0;
      div_d = 8'h00;
    end else if (tick) begin
      if (cnt_q >= limit - CNT_W'(1)) begin
        fire_d = 1'b1;
        cnt_d  = '0;
      end else begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      div_q  <= 8'h00;
      cnt_q  <= '0;
      fire_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      cnt_q  <= cnt_d;
      fire_q <= fire_d;
    end
  end

  always_comb begin
    flag_d = flag_q;
    if (!started_q) begin
      // reset cause kept over a watchdog reset
      flag_d = flag_q | pin_q[1];
    end
    if (bus.flag_clr) begin
      flag_d = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (fire_d) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  always_comb begin
    running_d = en_eff;
    addr_d    = RESET_VECTOR;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      running_q <= 1'b0;
      addr_q    <= RESET_VECTOR;
    end else begin
      running_q <= running_d;
      addr_q    <= addr_d;
    end
  end

  always_comb begin
    bus.rd_data             = '0;
    bus.rd_data[BIT_SEL3]   = sel_q[3];
    bus.rd_data[2:0]        = sel_q[2:0];
    bus.rd_data[BIT_UNLOCK] = unl_q;
    bus.rd_data[BIT_ENABLE] = en_eff;
  end

  assign bus.reset_flag   = flag_q;
  assign wdog_reset_out   = fire_q;
  assign restart_addr_out = addr_q;
  assign running_out      = running_q;
endmodule
`default_nettype wire

//--- design/wdog_pkg.sv
// shared constants and types for the watchdog configuration block
`default_nettype none
package wdog_pkg;
  localparam int          SEL_W          = 4;
  localparam logic [3:0]  SEL_MAX        = 4'h9;
  localparam logic [3:0]  SEL_RST        = 4'h0;
  localparam int          BASE_CYCLES    = 2048;
  localparam int          CNT_W          = 21;
  localparam int          UNLOCK_CYCLES  = 4;
  localparam logic [2:0]  UNLOCK_CNT_MAX = 3'h4;
  localparam logic [15:0] RESET_VECTOR   = 16'h0000;
  // control register bit positions
  localparam int          BIT_SEL3       = 5;
  localparam int          BIT_UNLOCK     = 4;
  localparam int          BIT_ENABLE     = 3;
  localparam int          CTRL_W         = 8;
  // clock and oscillator rates
  localparam int          SYS_HZ         = 10_000_000;
  localparam int          WDOG_OSC_HZ    = 128_000;
  localparam int          OSC_DIV        = SYS_HZ / WDOG_OSC_HZ;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_WRITE,
    OP_KICK
  } op_t;
endpackage
`default_nettype wire

//--- design/wdog_if.sv
// register write path between core software and the watchdog
`default_nettype none
interface wdog_if;
  import wdog_pkg::*;
  logic              wr_en;
  logic [CTRL_W-1:0] wr_data;
  logic              kick;
  logic [CTRL_W-1:0] rd_data;
  logic              flag_clr;
  logic              reset_flag;
  modport device (input wr_en, wr_data, kick, flag_clr,
                  output rd_data, reset_flag);
  modport core (output wr_en, wr_data, kick, flag_clr,
                input rd_data, reset_flag);
endinterface
`default_nettype wire

//--- design/wdog_core_end.sv
// core-side sequencer that issues register writes to the watchdog
`default_nettype none
module wdog_core_end
  import wdog_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  // user requests
  input  wire logic             req_in,
  input  wire op_t              req_op_in,
  input  wire logic [CTRL_W-1:0] req_data_in,
  input  wire logic             req_unlock_in,
  input  wire logic             flag_clr_in,
  output logic                  busy_out,
  output logic [CTRL_W-1:0]     ctrl_read_out,
  // watchdog side
  wdog_if.core                  bus
);
  typedef enum logic [1:0] {S_IDLE, S_UNLOCK, S_FINAL} st_t;
  st_t               st_q, st_d;
  logic              wr_q, wr_d, kick_q, kick_d, clr_q, clr_d;
  logic [CTRL_W-1:0] dat_q, dat_d, hold_q, hold_d, rd_q;

  always_comb begin
    st_d = st_q;
    wr_d = 1'b0;
    kick_d = 1'b0;
    clr_d = flag_clr_in;
    dat_d = dat_q;
    hold_d = hold_q;
    unique case (st_q)
      S_IDLE: if (req_in) begin
        if (req_op_in == OP_KICK) kick_d = 1'b1;
        else if (req_op_in == OP_WRITE && req_unlock_in) begin
          // keep current timeout in the unlock write
          dat_d = bus.rd_data;
          dat_d[BIT_UNLOCK] = 1'b1;
          dat_d[BIT_ENABLE] = 1'b1;
          wr_d = 1'b1;
          hold_d = req_data_in;
          st_d = S_UNLOCK;
        end else if (req_op_in == OP_WRITE) begin
          dat_d = req_data_in;
          wr_d = 1'b1;
        end
      end
      S_UNLOCK: begin
        // back to back final write lands inside the window
        dat_d = hold_q;
        dat_d[BIT_UNLOCK] = 1'b0;
        wr_d = 1'b1;
        st_d = S_FINAL;
      end
      S_FINAL: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_q <= S_IDLE;
      wr_q <= 1'b0;
      kick_q <= 1'b0;
      clr_q <= 1'b0;
      dat_q <= '0;
      hold_q <= '0;
      rd_q <= '0;
    end else begin
      st_q <= st_d;
      wr_q <= wr_d;
      kick_q <= kick_d;
      clr_q <= clr_d;
      dat_q <= dat_d;
      hold_q <= hold_d;
      rd_q <= bus.rd_data;
    end
  end

  // software never writes reserved codes; data is passed as given
  assign bus.wr_en = wr_q;
  assign bus.wr_data = dat_q;
  assign bus.kick = kick_q;
  assign bus.flag_clr = clr_q;
  assign busy_out = (st_q != S_IDLE);
  assign ctrl_read_out = rd_q;
endmodule
`default_nettype wire

//--- bench/wdog_properties.sv
// concurrent checks on the watchdog write path
`default_nettype none
module wdog_properties
  import wdog_pkg::*;
(
  // clock and reset
  input wire logic              clk_sys_in,
  input wire logic              rst_in,
  // interface signals
  input wire logic              wr_en,
  input wire logic [CTRL_W-1:0] wr_data,
  input wire logic              kick,
  input wire logic              flag_clr,
  input wire logic [CTRL_W-1:0] rd_data,
  input wire logic              reset_flag
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  property p_set; wr_en && wr_data[4:3] == 2'h3 |=> rd_data[4]; endproperty
  a_set: assert property (p_set)
    else $error("unlock bit not set");
  property p_clr;
    wr_en && wr_data[4:3] == 2'h3 ##1 !wr_en [*4] |=> !rd_data[4];
  endproperty
  a_clr: assert property (p_clr)
    else $error("unlock bit did not self clear");
  property p_src; $rose(rd_data[4]) |-> $past(wr_en && wr_data[4]); endproperty
  a_src: assert property (p_src)
    else $error("unlock bit rose without write");
  property p_force; reset_flag && $past(reset_flag) |-> rd_data[3]; endproperty
  a_force: assert property (p_force)
    else $error("enable low while flag set");
  property p_on; wr_en && wr_data[4:3] == 2'h1 |=> rd_data[3]; endproperty
  a_on: assert property (p_on)
    else $error("plain enable ignored");
  // disabling only with window open and flag clear
  property p_off;
    $fell(rd_data[3]) |-> $past(wr_en && !wr_data[3] && rd_data[4] && !reset_flag);
  endproperty
  a_off: assert property (p_off)
    else $error("enable dropped outside window");
  property p_late;
    wr_en && !wr_data[4] && !rd_data[4] && rd_data[3] |=> rd_data[3];
  endproperty
  a_late: assert property (p_late)
    else $error("late write lowered enable");
  property p_fclr; flag_clr |=> !reset_flag; endproperty
  a_fclr: assert property (p_fclr)
    else $error("flag not cleared");
endmodule
`default_nettype wire

//--- bench/tb_watchdog_timeout_config.sv
// bench for the watchdog pair: core end driving device end
`default_nettype none
module tb_watchdog_timeout_config
  import wdog_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 0, rst_in = 1, req_in = 0, req_unlock_in = 0;
  logic flag_clr_in = 0, lvl2 = 0, xflag = 0;
  op_t req_op_in = OP_NONE;
  logic [7:0] req_data_in = 8'h00, ctrl_read_out;
  logic [15:0] rnd = 16'h0010, restart_addr_out;
  logic busy_out, wdog_reset_out, running_out;
  int errors = 0, comparisons = 0, en = 0, sel = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  wdog_if bus ();
  wdog_core_end wdog_core_end_inst (.clk_sys_in, .rst_in, .req_in,
    .req_op_in, .req_data_in, .req_unlock_in, .flag_clr_in, .busy_out,
    .ctrl_read_out, .bus(bus.core));
  wdog_dev_end wdog_dev_end_inst (.clk_sys_in, .rst_in,
    .safety_level2_in(lvl2), .ext_reset_flag_in(xflag), .wdog_reset_out,
    .restart_addr_out, .running_out, .bus(bus.device));
  wdog_properties wdog_properties_inst (.clk_sys_in, .rst_in,
    .wr_en(bus.wr_en), .wr_data(bus.wr_data), .kick(bus.kick),
    .flag_clr(bus.flag_clr), .rd_data(bus.rd_data),
    .reset_flag(bus.reset_flag));
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask
  function automatic logic [15:0] xs(logic [15:0] v);
    logic [15:0] t;
    t = v ^ (v << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction
  function automatic logic [7:0] ctl(int e, int s);
    return {2'h0, s[3], 1'h0, e[0], s[2:0]};
  endfunction
  task automatic ck();
    chk({8'h00, ctrl_read_out & 8'h2f}, {8'h00, ctl(en, sel)});
    chk({15'h0, running_out}, 16'(en));
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  // bounded wait on busy, then let the read copy settle
  task automatic wr(logic [7:0] d, logic u);
    @(posedge clk_sys_in);
    req_in <= 1'b1;
    req_op_in <= OP_WRITE;
    req_data_in <= d;
    req_unlock_in <= u;
    @(posedge clk_sys_in);
    req_in <= 1'b0;
    cyc(2);
    for (int i = 0; i < 20 && busy_out !== 1'b0; i++) cyc(1);
    if (busy_out !== 1'b0) begin
      errors++;
      conclude();
    end
    cyc(3);
  endtask
  task automatic rst(logic l2, logic f);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    lvl2 <= l2;
    xflag <= f;
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    cyc(3);
  endtask
  initial begin
    rst(0, 0);
    ck();
    chk(restart_addr_out, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      rnd = xs(rnd);
      en = 1;
      sel = rnd % 10;
      wr(ctl(en, sel), 0);
      ck();
    end
    en = 0;
    wr(ctl(0, sel), 1);
    ck();
    en = 1;
    wr(ctl(1, sel), 0);
    wr(ctl(1, sel) | 8'h10, 0);
    wr(ctl(0, sel), 0);
    ck();
    $display("level1 done");
    rst(0, 1);
    sel = 0;
    ck();
    wr(ctl(0, 0), 1);
    ck();
    @(posedge clk_sys_in) flag_clr_in <= 1'b1;
    @(posedge clk_sys_in) flag_clr_in <= 1'b0;
    wr(ctl(0, 0), 1);
    en = 0;
    ck();
    $display("flag done");
    rst(1, 0);
    en = 1;
    ck();
    wr(ctl(0, 5), 0);
    ck();
    sel = 5;
    wr(ctl(0, 5), 1);
    ck();
    $display("level2 done");
    conclude();
  end
endmodule
`default_nettype wire
